// ---- src/accel_readout.v ----
// Overview of operation
// - Boot copies calibration, then enters power-down
// - Write 47h powers on, XYZ, 100 Hz
// - Status bit 3 shows fresh samples
// - Status bit 7 flags overwritten samples
// - Overrun clears after full read, no new
// - Data-ready pin mirrors flag, polarity selectable
// - Data-ready drops after all enabled axes read
// - Routing field 100 selects data-ready
// - Outputs two's complement, 18 mg per LSB
// - Two identical independent interrupt sources
// - Condition asserts request, source reports axes
// - Combination 0 ORs enabled comparators
// - Comparators test axis magnitude against threshold
// - Combination 1 needs all enabled comparators true
// - Unlatched request follows condition
// - Latched request holds until source read
// - Enable bits select axes and directions
// - Write C7h powers on at 400 Hz
// - Routing 01h to pin one, 08h two
// - Filter control 04h high-passes source one
// - Filter-reset read loads current reference
// - Reference applies at once, any time
// - Routing 001, 010, 011 select sources
// - Source read clears latched register and request
//
// Purpose: register file, sampling, status and pin routing of a three-axis accelerometer
// Assumes: classic Wishbone slave, ack one cycle after strobe; raw samples come from the sensing front end
// Notes: the calibration store is modelled as a parameter table copied at boot
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "accel_consts.vh"
module accel_readout #(
  parameter BOOT_CYCLES = `BOOT_CYCLES,
  parameter PERIOD_SLOW = `PERIOD_100_CYCLES,
  parameter PERIOD_FAST = `PERIOD_400_CYCLES,
  parameter [23:0] CAL_OFFSETS = 24'h000000
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [7:0] raw_x,
  input wire [7:0] raw_y,
  input wire [7:0] raw_z,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg booting,
  output reg interrupt_pin_one,
  output reg interrupt_pin_two
);
  // ====================================================
  // Register storage
  reg [7:0] power_rate_control_ff;
  reg [7:0] filter_control_ff;
  reg [7:0] pin_routing_control_ff;
  reg [7:0] event_configuration_one_ff;
  reg [7:0] event_configuration_two_ff;
  reg [7:0] event_threshold_one_ff;
  reg [7:0] event_threshold_two_ff;
  reg [7:0] event_min_duration_one_ff;
  reg [7:0] event_min_duration_two_ff;
  reg [23:0] calibration_ff;
  reg [23:0] out_ff;
  reg [23:0] reference_ff;
  reg [2:0] unread_ff;
  reg [2:0] overrun_ff;
  reg [31:0] boot_count_ff;
  reg [31:0] rate_count_ff;
  reg [7:0] x_sync1_ff;
  reg [7:0] y_sync1_ff;
  reg [7:0] z_sync1_ff;
  reg [23:0] raw_sync_ff;
  // ====================================================
  // Bus decode
  wire bus_req;
  wire [7:0] index;
  wire rd_strobe;
  wire wr_strobe;
  wire wr_lane0;
  // Ack high blocks a retake
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign index = wb_adr_i[9:2];
  assign rd_strobe = bus_req && !wb_we_i;
  assign wr_strobe = bus_req && wb_we_i;
  assign wr_lane0 = wr_strobe && wb_sel_i[0];
  // ====================================================
  // Sampling
  wire powered;
  wire [2:0] axis_en;
  wire [31:0] period;
  wire sample_tick;
  wire [23:0] calibrated;
  wire [23:0] filtered;
  wire [2:0] axis_read;
  wire all_read;
  wire ref_load;
  assign powered = power_rate_control_ff[`BIT_POWER_ON] &&
    !booting;
  assign axis_en = power_rate_control_ff[2:0];
  // bit 7 low selects 100 Hz; high selects 400 Hz
  assign period = power_rate_control_ff[`BIT_RATE_SELECT] ?
    PERIOD_FAST : PERIOD_SLOW;
  assign sample_tick = powered &&
    (rate_count_ff >= period - 32'd1);
  // calibrated two's complement sample, 18 mg per LSB at 2 g
  genvar a;
  generate
    for (a = 0; a < 3; a = a + 1)
    begin : g_axis
      assign calibrated[8*a+7:8*a] = raw_sync_ff[8*a+7:8*a] +
        calibration_ff[8*a+7:8*a];
      assign filtered[8*a+7:8*a] = calibrated[8*a+7:8*a] -
        reference_ff[8*a+7:8*a];
      assign axis_read[a] = rd_strobe &&
        (index == `IDX_X_AXIS_OUTPUT + 8'd2 * a[7:0]);
    end
  endgenerate
  // only enabled channels must be read
  assign all_read = ((unread_ff & ~axis_read) & axis_en) ==
    3'h0;
  // read of filter reset loads reference
  assign ref_load = rd_strobe &&
    (index == `IDX_FILTER_REFERENCE_RESET);
  // ====================================================
  // Interrupt sources
  wire [6:0] src_one_bits;
  wire [6:0] src_two_bits;
  wire req_one;
  wire req_two;
  wire [23:0] feed_one;
  wire [23:0] feed_two;
  assign feed_one = filter_control_ff[`BIT_HP_SOURCE_ONE] ?
    filtered : out_ff;
  assign feed_two = filter_control_ff[`BIT_HP_SOURCE_TWO] ?
    filtered : out_ff;
  event_source u_source_one (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .x_sample(feed_one[7:0]),
    .y_sample(feed_one[15:8]),
    .z_sample(feed_one[23:16]),
    .configuration(event_configuration_one_ff),
    .threshold(event_threshold_one_ff[6:0]),
    .clear_read(rd_strobe && index == `IDX_EVENT_SOURCE_ONE),
    .source_bits(src_one_bits),
    .request(req_one)
  );
  event_source u_source_two (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .x_sample(feed_two[7:0]),
    .y_sample(feed_two[15:8]),
    .z_sample(feed_two[23:16]),
    .configuration(event_configuration_two_ff),
    .threshold(event_threshold_two_ff[6:0]),
    .clear_read(rd_strobe && index == `IDX_EVENT_SOURCE_TWO),
    .source_bits(src_two_bits),
    .request(req_two)
  );
  // ====================================================
  // Status and routing
  wire new_data;
  wire overrun_any;
  wire [7:0] status_byte;
  assign new_data = |(unread_ff & axis_en);
  assign overrun_any = |(overrun_ff & axis_en);
  // bit 3 new data; bit 7 overrun
  assign status_byte = {overrun_any, 1'b0, 1'b0, 1'b0, new_data, 3'h0} |
    {4'h0, 1'b0, unread_ff};
  function route_pin;
    input [2:0] field;
    input ready;
    input one;
    input two;
    begin
      case (field)
        `ROUTE_SOURCE_ONE: route_pin = one;
        `ROUTE_SOURCE_TWO: route_pin = two;
        `ROUTE_SOURCE_EITHER: route_pin = one | two;
        `ROUTE_DATA_READY: route_pin = ready;
        // Reserved codes stay idle
        default: route_pin = 1'b0;
      endcase
    end
  endfunction
  wire pin_one_level;
  wire pin_two_level;
  wire polarity_low;
  assign polarity_low = pin_routing_control_ff[`BIT_INTERRUPT_POLARITY];
  assign pin_one_level = route_pin(pin_routing_control_ff[2:0],
    new_data, req_one, req_two);
  assign pin_two_level = route_pin(pin_routing_control_ff[5:3],
    new_data, req_one, req_two);
  // ====================================================
  // Read mux
  reg [7:0] rd_byte;
  always @*
  begin
    case (index)
      `IDX_POWER_RATE_CONTROL: rd_byte = power_rate_control_ff;
      `IDX_FILTER_CONTROL: rd_byte = filter_control_ff;
      `IDX_PIN_ROUTING_CONTROL: rd_byte = pin_routing_control_ff;
      `IDX_STATUS: rd_byte = status_byte;
      `IDX_X_AXIS_OUTPUT: rd_byte = out_ff[7:0];
      `IDX_Y_AXIS_OUTPUT: rd_byte = out_ff[15:8];
      `IDX_Z_AXIS_OUTPUT: rd_byte = out_ff[23:16];
      `IDX_EVENT_CONFIGURATION_ONE: rd_byte = event_configuration_one_ff;
      `IDX_EVENT_SOURCE_ONE: rd_byte = {1'b0, src_one_bits};
      `IDX_EVENT_THRESHOLD_ONE: rd_byte = event_threshold_one_ff;
      `IDX_EVENT_MIN_DURATION_ONE: rd_byte = event_min_duration_one_ff;
      `IDX_EVENT_CONFIGURATION_TWO: rd_byte = event_configuration_two_ff;
      `IDX_EVENT_SOURCE_TWO: rd_byte = {1'b0, src_two_bits};
      `IDX_EVENT_THRESHOLD_TWO: rd_byte = event_threshold_two_ff;
      `IDX_EVENT_MIN_DURATION_TWO: rd_byte = event_min_duration_two_ff;
      // Unmapped reads zero
      default: rd_byte = 8'h00;
    endcase
  end
  // ====================================================
  // Input synchroniser, front end is asynchronous
  // Word copied whole; front end holds it steady
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      x_sync1_ff <= 8'h00;
      y_sync1_ff <= 8'h00;
      z_sync1_ff <= 8'h00;
      raw_sync_ff <= 24'h000000;
    end
    else if (clk_en)
    begin
      x_sync1_ff <= raw_x;
      y_sync1_ff <= raw_y;
      z_sync1_ff <= raw_z;
      raw_sync_ff <= {z_sync1_ff, y_sync1_ff, x_sync1_ff};
    end
  end
  // ====================================================
  // Main sequential logic
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      power_rate_control_ff <= `RST_POWER_RATE_CONTROL;
      filter_control_ff <= `RST_ZERO_BYTE;
      pin_routing_control_ff <= `RST_ZERO_BYTE;
      event_configuration_one_ff <= `RST_ZERO_BYTE;
      event_configuration_two_ff <= `RST_ZERO_BYTE;
      event_threshold_one_ff <= `RST_ZERO_BYTE;
      event_threshold_two_ff <= `RST_ZERO_BYTE;
      event_min_duration_one_ff <= `RST_ZERO_BYTE;
      event_min_duration_two_ff <= `RST_ZERO_BYTE;
      calibration_ff <= 24'h000000;
      out_ff <= 24'h000000;
      reference_ff <= 24'h000000;
      unread_ff <= 3'h0;
      overrun_ff <= 3'h0;
      boot_count_ff <= 32'h00000000;
      rate_count_ff <= 32'h00000000;
      booting <= 1'b1;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      interrupt_pin_one <= 1'b0;
      interrupt_pin_two <= 1'b0;
    end
    else if (clk_en)
    begin
      // boot copy, then power-down (bit 6 stays low)
      if (booting)
      begin
        calibration_ff <= CAL_OFFSETS;
        boot_count_ff <= boot_count_ff + 32'd1;
        if (boot_count_ff >= BOOT_CYCLES - 1)
          booting <= 1'b0;
      end
      // One-cycle ack
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_strobe ?
        {24'h000000, rd_byte} : 32'h00000000;
      if (wr_lane0)
      begin
        case (index)
          `IDX_POWER_RATE_CONTROL: power_rate_control_ff <= wb_dat_i[7:0];
          `IDX_FILTER_CONTROL: filter_control_ff <= wb_dat_i[7:0];
          `IDX_PIN_ROUTING_CONTROL: pin_routing_control_ff <= wb_dat_i[7:0];
          `IDX_EVENT_CONFIGURATION_ONE: event_configuration_one_ff <= wb_dat_i[7:0];
          `IDX_EVENT_THRESHOLD_ONE: event_threshold_one_ff <= wb_dat_i[7:0];
          `IDX_EVENT_MIN_DURATION_ONE: event_min_duration_one_ff <= wb_dat_i[7:0];
          `IDX_EVENT_CONFIGURATION_TWO: event_configuration_two_ff <= wb_dat_i[7:0];
          `IDX_EVENT_THRESHOLD_TWO: event_threshold_two_ff <= wb_dat_i[7:0];
          `IDX_EVENT_MIN_DURATION_TWO: event_min_duration_two_ff <= wb_dat_i[7:0];
          default: power_rate_control_ff <= power_rate_control_ff;
        endcase
      end
      if (ref_load)
        reference_ff <= calibrated;
      // Idle while powered down
      if (!powered)
        rate_count_ff <= 32'h00000000;
      else if (sample_tick)
        rate_count_ff <= 32'h00000000;
      else
        rate_count_ff <= rate_count_ff + 32'd1;
      if (sample_tick)
      begin
        out_ff <= calibrated;
        // set on full sample; set wins over read clear
        unread_ff <= axis_en;
        overrun_ff <= overrun_ff |
          (unread_ff & ~axis_read & axis_en);
      end
      else
      begin
        unread_ff <= unread_ff & ~axis_read;
        // clear after all read, no new sample
        if (all_read)
          overrun_ff <= 3'h0;
      end
      // polarity bit inverts the pin level
      interrupt_pin_one <= pin_one_level ^ polarity_low;
      interrupt_pin_two <= pin_two_level ^ polarity_low;
    end
  end
endmodule
`default_nettype wire

// ---- src/accel_consts.vh ----
// Purpose: shared offsets, field positions, reset values and timing for the accelerometer readout block
// Assumes: 32-bit Wishbone word per register, byte address = 4 * index
// Notes: constants only
`ifndef ACCEL_CONSTS_VH
`define ACCEL_CONSTS_VH
// ====================================================
// Register indices (byte address = 4 * index)
`define IDX_POWER_RATE_CONTROL 8'h20
`define IDX_FILTER_CONTROL 8'h21
`define IDX_PIN_ROUTING_CONTROL 8'h22
`define IDX_FILTER_REFERENCE_RESET 8'h23
`define IDX_STATUS 8'h27
`define IDX_X_AXIS_OUTPUT 8'h29
`define IDX_Y_AXIS_OUTPUT 8'h2B
`define IDX_Z_AXIS_OUTPUT 8'h2D
`define IDX_EVENT_CONFIGURATION_ONE 8'h30
`define IDX_EVENT_SOURCE_ONE 8'h31
`define IDX_EVENT_THRESHOLD_ONE 8'h32
`define IDX_EVENT_MIN_DURATION_ONE 8'h33
`define IDX_EVENT_CONFIGURATION_TWO 8'h34
`define IDX_EVENT_SOURCE_TWO 8'h35
`define IDX_EVENT_THRESHOLD_TWO 8'h36
`define IDX_EVENT_MIN_DURATION_TWO 8'h37
// ====================================================
// Field positions
`define BIT_RATE_SELECT 7
`define BIT_POWER_ON 6
`define BIT_X_ENABLE 0
`define BIT_Y_ENABLE 1
`define BIT_Z_ENABLE 2
`define BIT_HP_SOURCE_ONE 2
`define BIT_HP_SOURCE_TWO 3
`define BIT_INTERRUPT_POLARITY 7
`define BIT_ALL_AXES_NEW_DATA 3
`define BIT_ALL_AXES_OVERRUN 7
`define BIT_COMBINATION 7
`define BIT_LATCH_REQUEST 6
`define BIT_SOURCE_ACTIVE 6
`define ROUTE_SOURCE_ONE 3'h1
`define ROUTE_SOURCE_TWO 3'h2
`define ROUTE_SOURCE_EITHER 3'h3
`define ROUTE_DATA_READY 3'h4
// ====================================================
// Reset values
`define RST_POWER_RATE_CONTROL 8'h07
`define RST_ZERO_BYTE 8'h00
// ====================================================
// Timing at 100 MHz
`define CLOCK_HZ 100000000
`define BOOT_TIME_US 3000
`define BOOT_CYCLES ((`BOOT_TIME_US * (`CLOCK_HZ / 1000000)))
`define RATE_100_HZ 100
`define RATE_400_HZ 400
`define PERIOD_100_CYCLES (`CLOCK_HZ / `RATE_100_HZ)
`define PERIOD_400_CYCLES (`CLOCK_HZ / `RATE_400_HZ)
`endif

// ---- src/axis_compare.v ----
// Purpose: high/low threshold comparison of one axis against a magnitude threshold
// Assumes: sample is two's complement, threshold is unsigned magnitude
// Notes: pure combinational
`timescale 1ns/1ps
`default_nettype none
module axis_compare #(
  parameter WIDTH = 8
) (
  input wire [WIDTH-1:0] sample,
  input wire [6:0] threshold,
  output wire above,
  output wire below
);
  wire [WIDTH-1:0] magnitude;
  // Most negative value wraps to itself, still larger than any threshold
  assign magnitude = sample[WIDTH-1] ? (~sample + {{(WIDTH-1){1'b0}}, 1'b1}) : sample;
  assign above = magnitude > {{(WIDTH-7){1'b0}}, threshold};
  assign below = ~above;
endmodule
`default_nettype wire

// ---- src/event_source.v ----
// Purpose: one free-fall/wake-up interrupt source with latch and source register
// Assumes: samples are compared on every clk_en cycle; clear_read pulses on a read of the source register
// Notes: latched flags hold until the source register is read
`timescale 1ns/1ps
`default_nettype none
`include "accel_consts.vh"
module event_source (
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [7:0] x_sample,
  input wire [7:0] y_sample,
  input wire [7:0] z_sample,
  input wire [7:0] configuration,
  input wire [6:0] threshold,
  input wire clear_read,
  output wire [6:0] source_bits,
  output wire request
);
  wire [5:0] hit;
  wire [5:0] enabled;
  wire [23:0] samples;
  wire condition;
  reg [6:0] held_ff;
  reg [6:0] nxt_held;
  assign samples = {z_sample, y_sample, x_sample};
  assign enabled = configuration[5:0];
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_axis
      axis_compare #(.WIDTH(8)) u_cmp (
        .sample(samples[8*i+7:8*i]),
        .threshold(threshold),
        .above(hit[2*i+1]),
        .below(hit[2*i])
      );
    end
  endgenerate
  // OR of enabled comparators; all enabled below (low enables give that form)
  // enable bits pick axis and direction
  assign condition = configuration[`BIT_COMBINATION] ?
    ((|enabled) && ((hit & enabled) == enabled)) : (|(hit & enabled));
  // report axes and request; follow or latch
  always @*
  begin
    nxt_held = held_ff;
    if (!configuration[`BIT_LATCH_REQUEST])
      nxt_held = {condition, hit & enabled & {6{condition}}};
    else
    begin
      // read clears; a new event in the same cycle wins
      if (clear_read)
        nxt_held = 7'h00;
      if (condition)
        nxt_held = {1'b1, (clear_read ? 6'h00 : held_ff[5:0]) | (hit & enabled)};
    end
  end
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      held_ff <= 7'h00;
    else if (clk_en)
      held_ff <= nxt_held;
  end
  assign source_bits = held_ff;
  assign request = held_ff[6];
endmodule
`default_nettype wire

// ---- test/accel_readout_props.sv ----
// Purpose: port-level checker for the accelerometer readout block
// Assumes: ack one cycle after a taken request
// Notes: shadows control writes seen on the bus
`timescale 1ns/1ps
`default_nettype none
module accel_readout_props #(
  parameter BOOT_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic booting,
  input wire logic interrupt_pin_one,
  input wire logic interrupt_pin_two
);
  logic [31:0] boot_cnt_ff;
  logic [7:0] route_ff;
  logic [7:0] power_ff;
  wire logic wr_done;
  wire logic rd_done;
  wire logic [7:0] idx;
  assign wr_done = wb_ack_o && wb_we_i && wb_sel_i[0];
  assign rd_done = wb_ack_o && !wb_we_i;
  assign idx = wb_adr_i[9:2];
  // ========
  // Shadow of boot time and control writes
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      boot_cnt_ff <= 32'h00000000;
      route_ff <= 8'h00;
      power_ff <= 8'h07;
    end
    else if (clk_en)
    begin
      if (boot_cnt_ff < BOOT_CYCLES + 4)
        boot_cnt_ff <= boot_cnt_ff + 32'h00000001;
      if (wr_done && idx == 8'h22)
        route_ff <= wb_dat_i[7:0];
      if (wr_done && idx == 8'h20)
        power_ff <= wb_dat_i[7:0];
    end
  end
  // ========
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_upper_data_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_unmapped_reads_zero: assert property (rd_done && idx < 8'h20 |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  a_filter_reads_zero: assert property (rd_done && idx == 8'h23 |-> wb_dat_o[7:0] == 8'h00)
    else $error("filter reset read not zero");
  a_boot_still_busy: assert property (boot_cnt_ff < BOOT_CYCLES - 1 |-> booting)
    else $error("boot ended early");
  a_boot_is_over: assert property (boot_cnt_ff > BOOT_CYCLES + 1 |-> !booting)
    else $error("boot ended late");
  a_pin_one_idle: assert property ($stable(route_ff) && route_ff[2:0] == 3'h0 |-> interrupt_pin_one == route_ff[7])
    else $error("unrouted pin one not idle");
  a_pin_two_idle: assert property ($stable(route_ff) && route_ff[5:3] == 3'h0 |-> interrupt_pin_two == route_ff[7])
    else $error("unrouted pin two not idle");
  a_power_read_back: assert property (rd_done && idx == 8'h20 |-> wb_dat_o[7:0] == power_ff)
    else $error("power control read back wrong");
  a_route_read_back: assert property (rd_done && idx == 8'h22 |-> wb_dat_o[7:0] == route_ff)
    else $error("routing read back wrong");
  c_read: cover property (rd_done);
  c_pin_one_rise: cover property ($rose(interrupt_pin_one));
  c_boot_done: cover property ($fell(booting));
endmodule
bind accel_readout accel_readout_props #(.BOOT_CYCLES(BOOT_CYCLES)) props_u (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .booting(booting), .interrupt_pin_one(interrupt_pin_one), .interrupt_pin_two(interrupt_pin_two));
`default_nettype wire

// ---- test/wb_host_model.sv ----
// Purpose: host side of the register bus
// Assumes: classic single cycle, one request at a time
// Notes: the wait for ack is bounded; the caller handles a timeout
`timescale 1ns/1ps
`default_nettype none
module wb_host_model (
  input wire logic sys_clk,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [9:0] wb_adr_i,
  output logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_i
);
  initial
  begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
  end
  // ========
  // One bus cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
    output logic [7:0] q, output logic to);
    int n;
    begin
      q = 8'h00;
      to = 1'b1;
      n = 0;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'hF;
      wb_dat_i <= {24'h000000, d};
      while (to && n < 50)
      begin
        @(posedge sys_clk);
        n++;
        if (wb_ack_o === 1'b1)
        begin
          to = 1'b0;
          q = wb_dat_o[7:0];
        end
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- test/accel_status_and_motion_irq_tb_top.sv ----
// Purpose: self-checking bench for the accelerometer readout block
// Assumes: shortened boot and sample periods
// Notes: reads queue their expectation; a monitor compares on ack
`timescale 1ns/1ps
`default_nettype none
`include "accel_consts.vh"
module accel_status_and_motion_irq_tb_top;
  localparam int BOOT = 20;
  localparam int PS = 400;
  localparam int PF = 100;
  logic sys_clk, sys_rst, cyc, stb, we, ack, booting, p1, p2, to;
  logic [7:0] raw_x, raw_y, raw_z, q, rx, ry, rz;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r;
  logic [23:0] exp_q[$];
  logic [23:0] e;
  logic [7:0] rt [6] = '{8'h01, 8'h08, 8'h02, 8'h0B, 8'h10, 8'h81};
  logic [5:0] e1 = 6'b001001;
  logic [5:0] e2 = 6'b101010;
  int n_errors, num_checks, tick, n, t0;
  accel_readout #(.BOOT_CYCLES(BOOT), .PERIOD_SLOW(PS), .PERIOD_FAST(PF)) dut_u (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .clk_en(1'b1), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .booting(booting), .interrupt_pin_one(p1), .interrupt_pin_two(p2));
  wb_host_model host_u (.sys_clk(sys_clk), .wb_ack_o(ack), .wb_dat_o(dat_r), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) tick <= tick + 1;
  // ========
  // Checking and closing
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    begin
      num_checks++;
      if (seen !== exp)
      begin
        n_errors++;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task automatic results;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task automatic fail(input string what);
    begin
      n_errors++;
      $display("ERROR %s expected done seen hang", what);
      results();
    end
  endtask
  always @(posedge sys_clk)
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (e[15:8] !== 8'h00)
        check($sformatf("reg %h", e[23:16]), dat_r[7:0] & e[15:8], e[7:0] & e[15:8]);
    end
  // ========
  // Bus and timing helpers
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    begin
      host_u.xfer(w, idx, d, q, to);
      if (to)
        fail("bus answer");
    end
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] v, input logic [7:0] m);
    begin
      exp_q.push_back({idx, m, v});
      bus(1'b0, idx, 8'h00);
    end
  endtask
  task automatic pins(input logic a, input logic b);
    begin
      repeat (2) @(posedge sys_clk);
      check("pin one", {7'h00, p1}, {7'h00, a});
      check("pin two", {7'h00, p2}, {7'h00, b});
    end
  endtask
  // Clears unread data, then waits for the next sample set
  task automatic wait_sample;
    begin
      repeat (4) @(posedge sys_clk);
      rd(`IDX_X_AXIS_OUTPUT, 8'h00, 8'h00);
      rd(`IDX_Y_AXIS_OUTPUT, 8'h00, 8'h00);
      rd(`IDX_Z_AXIS_OUTPUT, 8'h00, 8'h00);
      n = 0;
      q = 8'h00;
      while (q[3] !== 1'b1 && n < 500)
      begin
        rd(`IDX_STATUS, 8'h00, 8'h00);
        n++;
      end
      if (n >= 500)
        fail("new data");
      repeat (3) @(posedge sys_clk);
    end
  endtask
  task automatic period(input int p);
    begin
      wait_sample;
      t0 = tick;
      wait_sample;
      check("sample period", 8'((tick - t0 >= p - 8) && (tick - t0 <= p + 8)), 8'h01);
    end
  endtask
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    fail("run length");
  end
  // ========
  // Main sequence
  initial
  begin
    void'($urandom(91));
    sys_rst = 1'b1;
    raw_x = 8'h00;
    raw_y = 8'h00;
    raw_z = 8'h00;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    n = 0;
    while (booting !== 1'b0 && n < 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    check("boot length", 8'(n >= BOOT - 2 && n <= BOOT + 2), 8'h01);
    rd(`IDX_POWER_RATE_CONTROL, 8'h07, 8'hFF);
    rd(8'h10, 8'h00, 8'hFF);
    $display("test boot done");
    bus(1'b1, `IDX_POWER_RATE_CONTROL, 8'h47);
    period(PS);
    rx = 8'($urandom);
    ry = 8'($urandom);
    rz = 8'($urandom);
    raw_x <= rx;
    raw_y <= ry;
    raw_z <= rz;
    wait_sample;
    wait_sample;
    bus(1'b1, `IDX_PIN_ROUTING_CONTROL, 8'h24);
    pins(1'b1, 1'b1);
    rd(`IDX_STATUS, 8'h08, 8'h08);
    rd(`IDX_X_AXIS_OUTPUT, rx, 8'hFF);
    rd(`IDX_Y_AXIS_OUTPUT, ry, 8'hFF);
    pins(1'b1, 1'b1);
    rd(`IDX_Z_AXIS_OUTPUT, rz, 8'hFF);
    pins(1'b0, 1'b0);
    rd(`IDX_STATUS, 8'h00, 8'h08);
    bus(1'b1, `IDX_PIN_ROUTING_CONTROL, 8'hA4);
    pins(1'b1, 1'b1);
    bus(1'b1, `IDX_PIN_ROUTING_CONTROL, 8'h00);
    $display("test data ready done");
    wait_sample;
    repeat (2 * PS - 40) @(posedge sys_clk);
    rd(`IDX_STATUS, 8'h88, 8'h88);
    wait_sample;
    rd(`IDX_STATUS, 8'h00, 8'h80);
    $display("test overrun done");
    bus(1'b1, `IDX_POWER_RATE_CONTROL, 8'hC7);
    period(PF);
    bus(1'b1, `IDX_EVENT_THRESHOLD_ONE, 8'h0A);
    bus(1'b1, `IDX_EVENT_THRESHOLD_TWO, 8'h0A);
    bus(1'b1, `IDX_EVENT_CONFIGURATION_ONE, 8'h02);
    bus(1'b1, `IDX_EVENT_CONFIGURATION_TWO, 8'h08);
    raw_x <= 8'h14;
    raw_y <= 8'h00;
    raw_z <= 8'h00;
    wait_sample;
    rd(`IDX_EVENT_SOURCE_ONE, 8'h42, 8'hFF);
    rd(`IDX_EVENT_SOURCE_TWO, 8'h00, 8'hFF);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, `IDX_PIN_ROUTING_CONTROL, rt[i]);
      pins(e1[i], e2[i]);
    end
    rd(`IDX_PIN_ROUTING_CONTROL, 8'h81, 8'hFF);
    bus(1'b1, `IDX_PIN_ROUTING_CONTROL, 8'h01);
    raw_x <= 8'hF0;
    wait_sample;
    pins(1'b1, 1'b0);
    raw_x <= 8'h05;
    wait_sample;
    pins(1'b0, 1'b0);
    bus(1'b1, `IDX_EVENT_CONFIGURATION_ONE, 8'h42);
    raw_x <= 8'h14;
    wait_sample;
    pins(1'b1, 1'b0);
    raw_x <= 8'h00;
    wait_sample;
    pins(1'b1, 1'b0);
    rd(`IDX_EVENT_SOURCE_ONE, 8'h42, 8'hFF);
    pins(1'b0, 1'b0);
    bus(1'b1, `IDX_EVENT_CONFIGURATION_ONE, 8'h95);
    wait_sample;
    pins(1'b1, 1'b0);
    raw_y <= 8'h20;
    wait_sample;
    pins(1'b0, 1'b0);
    bus(1'b1, `IDX_PIN_ROUTING_CONTROL, 8'h02);
    pins(1'b1, 1'b0);
    bus(1'b1, `IDX_PIN_ROUTING_CONTROL, 8'h01);
    $display("test events done");
    bus(1'b1, `IDX_EVENT_CONFIGURATION_ONE, 8'h02);
    bus(1'b1, `IDX_FILTER_CONTROL, 8'h04);
    raw_y <= 8'h00;
    raw_x <= 8'h30;
    wait_sample;
    pins(1'b1, 1'b0);
    rd(`IDX_FILTER_REFERENCE_RESET, 8'h00, 8'hFF);
    wait_sample;
    pins(1'b0, 1'b0);
    raw_x <= 8'h40;
    wait_sample;
    pins(1'b1, 1'b0);
    $display("test filter done");
    results();
  end
endmodule
`default_nettype wire
